// ==== core/ctp_timers.sv ====
// four 8-bit down counters in two cascadable pairs, pair zero doubling as a pwm,
// with a toggle output, sticky interrupts and an AXI4-Lite register slave
// assumes a single synchronous clock domain and a master that keeps AXI4-Lite rules
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// RL1 - joined pair interrupts only when full 16-bit count expires, on even timer; joined pair zero raises timer one at high phase end
// RL2 - in a joined pair the even timer holds low byte, odd holds high byte
// RL3 - count register loads from reload register in the cycle the interrupt posts
// RL4 - a joined pair always reloads on timeout regardless of reload option
// RL5 - counters keep running with pending interrupts; timers and pairs are independent
// RL6 - a second expiry before service is not detected; no overrun flag
// RL7 - control write starts enabled timers from current count, no reload
// RL8 - timers use the internal clock only, updating every eighth clock
// RL9 - separate timers zero and one are 8-bit, own interrupt, optional reload
// RL10 - joined pair zero builds low and high 16-bit reloads, timer one upper byte
// RL11 - joined pair zero reloads alternately from low pair then high pair
// RL12 - pwm first runs from count; first reload follows pin in output mode else low
// RL13 - low phase end raises timer zero interrupt, high phase end raises timer one
// RL14 - software must make port b bit one an output with its special function on
// RL15 - each timer zero end of count toggles the output flip-flop driving the pin
// RL16 - timer zero in continuous mode gives an even square wave on the pin
// RL17 - in pwm the pin goes low after high phase and high after low phase
// RL18 - each tick decrements an enabled counter by one; action on reaching zero
module ctp_timers #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              I_MCLK,
  input  wire logic              I_NRST,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  // axi4-lite write response
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  // timer output pin and interrupt
  output logic                   O_TOUT,
  output logic                   O_TOUT_OE,
  output logic                   O_IRQ
);
  import ctp_pkg::*;

  if (ADDR_W < IDX_W + 2) begin : g_bad_width
    $error("ADDR_W too narrow for the register map");
  end

  logic [CTRL_W-1:0] ctrl;
  logic [3:0]        en;
  logic [3:0]        rl;
  logic [1:0]        cas;
  logic [7:0]        rlo [4];
  logic [7:0]        rhi0;
  logic [7:0]        rhi1;
  logic [3:0]        status;
  logic [3:0]        mask;
  logic [7:0]        pb_dir;
  logic [7:0]        pb_sfr;
  logic [7:0]        cnt_rd [4];
  logic [3:0]        irq_set;
  logic [3:0]        wr_cnt;
  logic [1:0]        exp16;
  logic [1:0]        phase;
  logic              tff;
  logic              tout_mode;
  logic [2:0]        presc;
  logic              tick;
  logic              aw_full;
  logic              w_full;
  logic [IDX_W-1:0]  widx;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wr_fire;
  logic              ctrl_wr;
  logic [IDX_W-1:0]  ridx;
  logic [31:0]       next_rdata;
  logic              rd_hit;

  assign en  = ctrl[CTRL_EN_LSB +: 4];
  assign rl  = ctrl[CTRL_RL_LSB +: 4];
  assign cas = ctrl[CTRL_CAS_LSB +: 2];
  assign tout_mode = pb_dir[TOUT_BIT] & pb_sfr[TOUT_BIT]; // RL14

  // prescaler: no external clock input exists for the timers
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      presc <= 3'h0;
    end else begin
      presc <= presc + 3'h1; // RL8
    end
  end
  assign tick = (presc == TICK_LAST); // RL8

  // ---- axi4-lite write path: address and data are held until both are present
  assign O_AWREADY = !aw_full && !O_BVALID;
  assign O_WREADY  = !w_full && !O_BVALID;
  assign wr_fire   = aw_full && w_full && !O_BVALID;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_full <= 1'b0;
      widx    <= '0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_full <= 1'b1;
      widx    <= I_AWADDR[IDX_W+1:2];
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      w_full <= 1'b0;
      wdata  <= 32'h0000_0000;
      wstrb  <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      w_full <= 1'b1;
      wdata  <= I_WDATA;
      wstrb  <= I_WSTRB;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx <= IDX_MASK) || (idx == IDX_PB_DIR) || (idx == IDX_PB_SFR);
  endfunction

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // ---- configuration registers
  assign ctrl_wr = wr_fire && (widx == IDX_CTRL);

  // a control write changes enables, reload options and cascades and re-arms the phase; counts stay as they are
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      if (wstrb[0]) begin
        ctrl[7:0] <= wdata[7:0]; // RL7
      end
      if (wstrb[1]) begin
        ctrl[CTRL_W-1:8] <= wdata[CTRL_W-1:8];
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < 4; i++) begin
        rlo[i] <= 8'h00;
      end
      rhi0   <= 8'h00;
      rhi1   <= 8'h00;
      mask   <= 4'h0;
      pb_dir <= PB_RESET;
      pb_sfr <= PB_RESET;
    end else if (wr_fire && wstrb[0]) begin
      for (int i = 0; i < 4; i++) begin
        if (widx == IDX_RLO0 + IDX_W'(i)) begin
          rlo[i] <= wdata[7:0];
        end
      end
      if (widx == IDX_RHI0) rhi0 <= wdata[7:0];
      if (widx == IDX_RHI1) rhi1 <= wdata[7:0];
      if (widx == IDX_MASK) mask <= wdata[3:0];
      if (widx == IDX_PB_DIR) pb_dir <= wdata[7:0];
      if (widx == IDX_PB_SFR) pb_sfr <= wdata[7:0];
    end
  end

  // sticky status, write one to clear; a new event beats a clear in the same cycle.
  // only one bit per source, so a repeated expiry before service is simply merged
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status <= 4'h0;
    end else if (wr_fire && wstrb[0] && widx == IDX_STATUS) begin
      status <= (status & ~wdata[3:0]) | irq_set; // RL6
    end else begin
      status <= status | irq_set; // RL5
    end
  end
  assign O_IRQ = |(status & mask);

  // ---- the two timer pairs
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam int E = 2 * p;
    localparam int O = 2 * p + 1;
    localparam bit PWM = (p == 0);
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        ph;
    logic [15:0] val16;
    logic [15:0] reload16;
    logic        exp_lo;
    logic        exp_hi;
    logic        e16;
    logic        run_lo;
    logic        run_hi;

    assign val16 = {hi, lo}; // RL2
    // ph high: a high phase is ending, so the low pair loads next
    assign reload16 = (PWM && !ph) ? {(p == 0) ? rhi1 : 8'h00, (p == 0) ? rhi0 : 8'h00}
                                   : {rlo[O], rlo[E]}; // RL10
    // a stopped one-shot sits at zero instead of wrapping
    assign run_lo = en[E] && !(lo == 8'h00 && !rl[E]);
    assign run_hi = en[O] && !(hi == 8'h00 && !rl[O]);
    assign exp_lo = tick && run_lo && !cas[p] && (lo == 8'h01); // RL9
    assign exp_hi = tick && run_hi && !cas[p] && (hi == 8'h01); // RL9
    assign e16    = tick && en[E] && cas[p] && (val16 == 16'h0001); // RL1
    assign wr_cnt[E] = wr_fire && wstrb[0] && (widx == IDX_CNT0 + IDX_W'(E));
    assign wr_cnt[O] = wr_fire && wstrb[0] && (widx == IDX_CNT0 + IDX_W'(O));
    assign irq_set[E] = exp_lo || (e16 && !(PWM && ph)); // RL13
    assign irq_set[O] = exp_hi || (e16 && PWM && ph); // RL13
    assign exp16[p] = e16;
    assign phase[p] = ph;
    assign cnt_rd[E] = lo;
    assign cnt_rd[O] = hi;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
        lo <= 8'h00;
        hi <= 8'h00;
      end else begin
        if (cas[p]) begin
          if (e16) begin
            {hi, lo} <= reload16; // RL4
          end else if (tick && en[E]) begin
            {hi, lo} <= val16 - 16'h0001; // RL18
          end
        end else begin
          if (exp_lo) begin
            lo <= rl[E] ? rlo[E] : 8'h00; // RL3
          end else if (tick && run_lo) begin
            lo <= lo - 8'h01; // RL5
          end
          if (exp_hi) begin
            hi <= rl[O] ? rlo[O] : 8'h00; // RL3
          end else if (tick && run_hi) begin
            hi <= hi - 8'h01; // RL18
          end
        end
        // software load of a count wins over the decrement
        if (wr_cnt[E]) lo <= wdata[7:0];
        if (wr_cnt[O]) hi <= wdata[7:0];
      end
    end

    // phase is armed at each start so the first reload follows the pin or goes low
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
        ph <= 1'b1;
      end else if (ctrl_wr) begin
        ph <= tout_mode ? tff : 1'b1; // RL12
      end else if (e16) begin
        ph <= !ph; // RL11
      end
    end
  end

  // timer output flip-flop, clocked by the timer zero end of count
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tff <= 1'b0;
    end else if (cas[0] && exp16[0]) begin
      tff <= !phase[0]; // RL17
    end else if (irq_set[0]) begin
      tff <= !tff; // RL15 RL16
    end
  end
  assign O_TOUT    = tff;
  assign O_TOUT_OE = tout_mode; // RL14

  // ---- axi4-lite read path: one cycle to data
  assign O_ARREADY = !O_RVALID;
  assign ridx      = I_ARADDR[IDX_W+1:2];
  assign rd_hit    = mapped(ridx);

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ridx == IDX_CTRL) next_rdata[CTRL_W-1:0] = ctrl;
    for (int i = 0; i < 4; i++) begin
      if (ridx == IDX_CNT0 + IDX_W'(i)) next_rdata[7:0] = cnt_rd[i];
      if (ridx == IDX_RLO0 + IDX_W'(i)) next_rdata[7:0] = rlo[i];
    end
    if (ridx == IDX_RHI0) next_rdata[7:0] = rhi0;
    if (ridx == IDX_RHI1) next_rdata[7:0] = rhi1;
    if (ridx == IDX_STATUS) next_rdata[3:0] = status;
    if (ridx == IDX_MASK) next_rdata[3:0] = mask;
    if (ridx == IDX_PB_DIR) next_rdata[7:0] = pb_dir;
    if (ridx == IDX_PB_SFR) next_rdata[7:0] = pb_sfr;
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= next_rdata;
      O_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // ---- checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  sequence s_tick_gap;
    !tick [*7] ##1 tick;
  endsequence

  sequence s_high_end;
    cas[0] && exp16[0] && phase[0];
  endsequence

  sequence s_low_end;
    cas[0] && exp16[0] && !phase[0];
  endsequence

  a_tick_period: assert property (tick |=> s_tick_gap) // RL8
    else $error("timer tick spacing is not eight clocks");

  a_pair_odd_quiet: assert property (cas[1] |-> !irq_set[3]) // RL1
    else $error("odd timer of a joined pair raised its own interrupt");

  a_pair_reload: assert property (exp16[1] && !wr_cnt[2] && !wr_cnt[3]
    |=> {cnt_rd[3], cnt_rd[2]} == {$past(rlo[3]), $past(rlo[2])}) // RL4
    else $error("joined pair did not reload from its reload registers");

  a_single_reload: assert property (irq_set[2] && !cas[1] && rl[2] && !wr_cnt[2]
    |=> cnt_rd[2] == $past(rlo[2])) // RL3
    else $error("timer two did not reload with its interrupt");

  a_step_by_one: assert property (tick && en[0] && !cas[0] && cnt_rd[0] > 8'h01
    && !wr_cnt[0] |=> cnt_rd[0] == $past(cnt_rd[0]) - 8'h01) // RL18
    else $error("timer zero did not step down by one");

  a_hold_between: assert property (!tick && !wr_cnt[1] && !exp16[0]
    |=> cnt_rd[1] == $past(cnt_rd[1])) // RL8
    else $error("timer one moved without a tick");

  // a control write in the same cycle re-arms the phase, so it is left out here
  a_pwm_low_load: assert property ((s_high_end and (!wr_cnt[0] && !wr_cnt[1] && !ctrl_wr))
    |-> irq_set[1] ##1 ({cnt_rd[1], cnt_rd[0]} == {$past(rlo[1]), $past(rlo[0])}
    && !phase[0])) // RL13
    else $error("end of high phase did not load the low pair");

  a_pwm_high_load: assert property ((s_low_end and (!wr_cnt[0] && !wr_cnt[1]))
    |-> irq_set[0] ##1 ({cnt_rd[1], cnt_rd[0]} == {$past(rhi1), $past(rhi0)})) // RL11
    else $error("end of low phase did not load the high pair");

  a_pwm_pin: assert property (s_high_end |=> !tff) // RL17
    else $error("pin not low after high phase");

  a_pin_toggle: assert property (irq_set[0] && !cas[0] |=> tff != $past(tff)) // RL15
    else $error("timer output did not toggle on timer zero expiry");

  a_set_wins: assert property (irq_set[1] |=> status[1]) // RL5
    else $error("interrupt event lost");

  a_irq_level: assert property (O_IRQ == |(status & mask))
    else $error("interrupt output disagrees with status and mask");
endmodule

// ==== core/ctp_pkg.sv ====
// constants for the cascadable timer block: register indices, field positions, timing
// assumes one 100 MHz clock, AXI4-Lite register access with one 32-bit word per index
package ctp_pkg;
  localparam int          IDX_W        = 10;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL     = 10'h000;
  localparam logic [9:0]  IDX_CNT0     = 10'h001;
  localparam logic [9:0]  IDX_RLO0     = 10'h005;
  localparam logic [9:0]  IDX_RHI0     = 10'h009;
  localparam logic [9:0]  IDX_RHI1     = 10'h00A;
  localparam logic [9:0]  IDX_STATUS   = 10'h00B;
  localparam logic [9:0]  IDX_MASK     = 10'h00C;
  localparam logic [9:0]  IDX_PB_DIR   = 10'h0D6;
  localparam logic [9:0]  IDX_PB_SFR   = 10'h0D7;
  // control word fields
  localparam int          CTRL_EN_LSB  = 0;
  localparam int          CTRL_RL_LSB  = 4;
  localparam int          CTRL_CAS_LSB = 8;
  localparam int          CTRL_W       = 10;
  localparam logic [9:0]  CTRL_RESET   = 10'h000;
  // port b bit that carries the timer output
  localparam int          TOUT_BIT     = 1;
  localparam logic [7:0]  PB_RESET     = 8'h00;
  // timer update rate: one tick every eighth clock
  localparam int          TICK_DIV     = 8;
  localparam logic [2:0]  TICK_LAST    = 3'(TICK_DIV - 1);
  localparam int          TICK_GAP     = TICK_DIV - 1;
  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage

// ==== tb/test_cascadable_timers_with_pwm.sv ====
// self-checking bench for the cascadable timer block: registers, interrupts, pin timing
// assumes the block's AXI4-Lite slave and a single 100 MHz clock
`timescale 1ns/1ps
module test_cascadable_timers_with_pwm;
  import ctp_pkg::*;
  logic        I_MCLK;
  logic        I_NRST;
  logic        awv, wv, bre, arv, rre;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d, q;
  logic [3:0]  wstrb;
  logic [1:0]  br, rr, r;
  logic        awr, wr, bv, arr, rv, tout, oe, irq;
  logic [7:0]  rl;
  logic [9:0]  idx;
  int          errors, total_checks, cyc, seed, t0, dt, i;

  ctp_timers ctp_timers_inst (
    .I_MCLK(I_MCLK), .I_NRST(I_NRST),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wr),
    .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bre),
    .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rre),
    .O_TOUT(tout), .O_TOUT_OE(oe), .O_IRQ(irq)
  );

  initial begin
    I_MCLK = 1'b0;
    forever #5 I_MCLK = ~I_MCLK;
  end

  task complete_run;
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang is cut short well beyond the longest scenario
  always @(posedge I_MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      complete_run;
    end
  end

  task check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task check_cyc(input int g, input int e);
    total_checks++;
    if (g != e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ready is combinational from state, so its value at the falling edge is the one
  // sampled at the next rising edge; all changes land by nonblocking after that edge
  task wr_reg(input logic [9:0] a_idx, input logic [31:0] v, output logic [1:0] resp);
    logic a, w, b;
    begin
      @(posedge I_MCLK);
      awa <= {a_idx, 2'b00};
      wd  <= v;
      awv <= 1'b1;
      wv  <= 1'b1;
      bre <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(negedge I_MCLK);
        a = awv & awr;
        w = wv & wr;
        b = bv;
        resp = br;
        @(posedge I_MCLK);
        if (a) awv <= 1'b0;
        if (w) wv <= 1'b0;
        if (b) bre <= 1'b0;
      end
    end
  endtask

  task rd_reg(input logic [9:0] a_idx, output logic [31:0] v, output logic [1:0] resp);
    logic a, b;
    begin
      @(posedge I_MCLK);
      ara <= {a_idx, 2'b00};
      arv <= 1'b1;
      rre <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(negedge I_MCLK);
        a = arv & arr;
        b = rv;
        v = rdat;
        resp = rr;
        @(posedge I_MCLK);
        if (a) arv <= 1'b0;
        if (b) rre <= 1'b0;
      end
    end
  endtask

  task wait_tout(input int lim);
    logic v;
    begin
      v = tout;
      dt = 0;
      do begin
        @(negedge I_MCLK);
        dt++;
      end while (tout === v && dt < lim);
    end
  endtask

  task wait_irq(input int lim);
    dt = 0;
    do begin
      @(negedge I_MCLK);
      dt++;
    end while (irq !== 1'b1 && dt < lim);
  endtask

  function automatic int ticks(input int n);
    return n * TICK_DIV;
  endfunction

  initial begin
    I_NRST = 1'b0;
    {awv, wv, bre, arv, rre} = 5'h00;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0;
    wstrb = 4'hF;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    seed = 95462;
    repeat (10) @(posedge I_MCLK);
    I_NRST <= 1'b1;
    // reset state and unmapped place
    for (i = 0; i <= 12; i++) begin
      rd_reg(10'(i), d, r);
      check_val(d, 32'h0);
    end
    check_val({29'h0, tout, oe, irq}, 32'h0);
    rd_reg(10'h3FF, d, r);
    check_val({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr_reg(10'h3FF, 32'hFFFFFFFF, r);
    check_val({30'h0, r}, {30'h0, RESP_SLVERR});
    // byte registers hold random data while every timer is stopped
    for (i = 1; i <= 12; i++) begin
      idx = (i == 11) ? IDX_PB_DIR : (i == 12) ? IDX_PB_SFR : 10'(i);
      d = $random(seed);
      wr_reg(idx, d, r);
      rd_reg(idx, q, r);
      check_val(q, {24'h0, d[7:0]});
    end
    wr_reg(IDX_MASK, 32'hFFFFFFFF, r);
    rd_reg(IDX_MASK, d, r);
    check_val(d, 32'h0000000F);
    // timer output configured as pin output with its special function
    wr_reg(IDX_PB_DIR, 32'h02, r);
    wr_reg(IDX_PB_SFR, 32'h02, r);
    check_val({31'h0, oe}, 32'h1);
    // one-shot timer zero starts from the count written, no reload on enable
    wr_reg(IDX_MASK, 32'h0, r);
    wr_reg(IDX_CNT0, 32'h05, r);
    wr_reg(IDX_CTRL, 32'h001, r);
    wait_tout(200);
    check_val(32'(dt >= 28 && dt <= 41), 32'h1);
    wait_tout(200);
    check_cyc(dt, 200);
    rd_reg(IDX_CNT0, d, r);
    check_val(d, 32'h0);
    rd_reg(IDX_STATUS, d, r);
    check_val(d, 32'h1);
    check_val({31'h0, irq}, 32'h0);
    wr_reg(IDX_MASK, 32'h1, r);
    check_val({31'h0, irq}, 32'h1);
    wr_reg(IDX_STATUS, 32'h1, r);
    check_val({31'h0, irq}, 32'h0);
    // continuous timer zero: random reload gives an even square wave
    rl = 8'h08 + {4'h0, 4'($random(seed))};
    wr_reg(IDX_CTRL, 32'h0, r);
    wr_reg(IDX_RLO0, {24'h0, rl}, r);
    wr_reg(IDX_CNT0, {24'h0, rl}, r);
    wr_reg(IDX_CTRL, 32'h011, r);
    wait_tout(400);
    for (i = 0; i < 3; i++) begin
      wait_tout(400);
      check_cyc(dt, ticks(int'(rl)));
    end
    // interrupt stays pending while the count keeps reloading and running
    rd_reg(IDX_STATUS, d, r);
    check_val(d, 32'h1);
    wait_tout(400);
    wr_reg(IDX_STATUS, 32'h1, r);
    rd_reg(IDX_STATUS, d, r);
    check_val(d, 32'h0);
    wr_reg(IDX_CTRL, 32'h0, r);
    // joined pair two/three: one interrupt on the even timer, forced reload
    wr_reg(IDX_STATUS, 32'hF, r);
    wr_reg(IDX_MASK, 32'h4, r);
    wr_reg(10'h003, 32'h02, r);
    wr_reg(10'h004, 32'h00, r);
    wr_reg(10'h007, 32'h04, r);
    wr_reg(10'h008, 32'h01, r);
    wr_reg(IDX_CTRL, 32'h204, r);
    wait_irq(200);
    t0 = cyc;
    rd_reg(10'h004, d, r);
    check_val(d, 32'h01);
    rd_reg(IDX_STATUS, d, r);
    check_val(d, 32'h4);
    wr_reg(IDX_STATUS, 32'h4, r);
    wait_irq(3000);
    check_cyc(cyc - t0, ticks(32'h104));
    // timer two on its own reloads from its low reload register
    wr_reg(IDX_STATUS, 32'h4, r);
    wr_reg(IDX_CTRL, 32'h044, r);
    wait_irq(200);
    rd_reg(10'h003, d, r);
    check_val(d, 32'h04);
    wr_reg(IDX_CTRL, 32'h0, r);
    // pwm on pair zero/one: low phase 2 ticks, high phase 5 ticks
    wr_reg(IDX_STATUS, 32'hF, r);
    wr_reg(IDX_MASK, 32'h3, r);
    wr_reg(IDX_CNT0, 32'h03, r);
    wr_reg(IDX_CNT0 + 10'h001, 32'h00, r);
    wr_reg(IDX_RLO0, 32'h02, r);
    wr_reg(10'h006, 32'h00, r);
    wr_reg(IDX_RHI0, 32'h05, r);
    wr_reg(IDX_RHI1, 32'h00, r);
    wr_reg(IDX_CTRL, 32'h101, r);
    wait_tout(200);
    check_val(32'(dt <= 41), 32'h1);
    for (i = 0; i < 4; i++) begin
      d = {31'h0, tout};
      wait_tout(200);
      check_cyc(dt, ticks(d[0] ? 5 : 2));
      check_val({31'h0, tout}, {31'h0, ~d[0]});
    end
    rd_reg(IDX_STATUS, d, r);
    check_val(d, 32'h3);
    check_val({31'h0, irq}, 32'h1);
    complete_run;
  end
endmodule
